// File: smps_seq.sv
// Protection sequencer top with AXI4-Lite status and control
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "smps_consts.svh"
module smps_seq
  import smps_pkg::*;
#(
  parameter int unsigned BO_CYC = `SMPS_CLK_HZ / 1000 * `SMPS_BO_MS,
  parameter int unsigned OPP_CYC = `SMPS_CLK_HZ / 1000 * `SMPS_OPP_MS,
  parameter int unsigned SS_CYC = `SMPS_CLK_HZ / 1000000 * `SMPS_SS_US,
  parameter int unsigned PHASE_CYC = `SMPS_PHASE_CYC
)
(
  input wire logic clock, // 10 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire smps_sense_t sense, // Comparator decisions
  output smps_drive_t drive_ff, // Gate and front-end controls
  input wire logic [31:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [31:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read valid
  input wire logic rready // Read ready
);

  // ****************************************
  // Derived cycle counts
  // ****************************************
  localparam int unsigned PER_HI = `SMPS_CLK_HZ / `SMPS_SW_HZ;
  localparam logic [15:0] PER_HIGH = 16'(PER_HI);
  localparam logic [15:0] PER_PEAK = 16'(PER_HI * `SMPS_PEAK_PER_PCT / 100);
  localparam logic [15:0] PER_LOW = 16'(PER_HI * `SMPS_LOW_PER_MUL);
  localparam logic [7:0] OVP_DLY = 8'(`SMPS_CLK_HZ / 1000000 * `SMPS_OVP_DLY_US);
  localparam logic [15:0] BLANK = 16'(`SMPS_BLANK_CYC);
  localparam logic [15:0] PH_LAST = 16'(PHASE_CYC - 1);
  localparam logic [15:0] SS_STEP = 16'(SS_CYC / 256);
  localparam logic [3:0] CN [4] = '{4'(`SMPS_CONSEC_N), 4'(`SMPS_MAXD_N),
                                   4'(`SMPS_CONSEC_N), 4'(`SMPS_CONSEC_N)};

  // ****************************************
  // State and internal registers
  // ****************************************
  smps_state_t st_ff; // Sequencer state
  smps_state_t nxt_st; // Next state
  logic [1:0] rst_left_ff; // Restart cycles still to go
  logic [1:0] nxt_rst_left; // Next restart count
  logic [15:0] ph_cnt_ff; // Protect phase timer
  logic brownin_ff; // Held mains sample above brown-in
  logic below_bo_ff; // Held mains sample below brownout
  logic protect_ok_ff; // Protect level reached at last detect
  logic [15:0] per_cnt_ff; // Position in switching period
  logic [7:0] fall_cnt_ff; // Cycles since gate fall
  logic [15:0] ss_cnt_ff; // Soft-start step timer
  logic [7:0] ramp_ff; // Soft-start peak level
  logic en_ff; // Software switching enable
  logic [`SMPS_FLT_W-1:0] fault_ff; // Sticky fault causes

  // ****************************************
  // Protect input time multiplex
  // ****************************************
  wire ph_end = (ph_cnt_ff == PH_LAST); // Phase boundary
  wire mains_end = ph_end && drive_ff.mains_phase; // Mains sample point
  wire temp_end = ph_end && !drive_ff.mains_phase; // Temperature sample point

  // Phase counter and held mains samples
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      ph_cnt_ff <= 16'h0;
      brownin_ff <= 1'b0;
      below_bo_ff <= 1'b0;
      protect_ok_ff <= 1'b0;
    end
    else
    begin
      ph_cnt_ff <= ph_end ? 16'h0 : ph_cnt_ff + 16'h1;
      if (mains_end)
      begin
        brownin_ff <= sense.mains_brownin;
        below_bo_ff <= !sense.mains_brownout;
      end
      if (temp_end)
        protect_ok_ff <= sense.protect_detect;
    end
  end

  // ****************************************
  // Switching period and gate
  // ****************************************
  wire run = (st_ff == ST_RUN); // Switching allowed
  smps_freq_t nxt_freq; // Frequency mode
  assign nxt_freq = sense.ctrl_low_power ? FQ_LOW :
                    sense.ctrl_peak_power ? FQ_PEAK : FQ_HIGH;
  wire [15:0] per_len = (drive_ff.freq_mode == FQ_LOW) ? PER_LOW :
                        (drive_ff.freq_mode == FQ_PEAK) ? PER_PEAK : PER_HIGH;
  wire [31:0] max_on_w = 32'(per_len) * 32'(`SMPS_DUTY_PCT) / 32'd100;
  wire [15:0] max_on = max_on_w[15:0]; // Longest on-time
  wire per_last = (per_cnt_ff >= per_len - 16'h1); // End of period
  wire per_start = run && (per_cnt_ff == 16'h0); // New stroke
  wire trip_ok = sense.peak_trip && (per_cnt_ff > BLANK);
  wire at_max = (per_cnt_ff >= max_on);
  wire nxt_gate = run && (per_start || (drive_ff.gate && !trip_ok && !at_max));
  wire gate_fall = drive_ff.gate && !nxt_gate; // Stroke end
  wire maxd_end = gate_fall && at_max && !trip_ok; // Ended by duty cap
  wire ovp_pt = (fall_cnt_ff == OVP_DLY);

  // Period and fall-delay counters
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      per_cnt_ff <= 16'h0;
      fall_cnt_ff <= 8'h0;
    end
    else
    begin
      per_cnt_ff <= (!run || per_last) ? 16'h0 : per_cnt_ff + 16'h1;
      fall_cnt_ff <= gate_fall ? 8'h1 : (fall_cnt_ff == 8'h0 || ovp_pt) ? 8'h0 : fall_cnt_ff + 8'h1;
    end
  end

  // ****************************************
  // Soft start ramp
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      ss_cnt_ff <= 16'h0;
      ramp_ff <= 8'h0;
    end
    else if (!run)
    begin
      ss_cnt_ff <= 16'h0; // Restart ramp at each start
      ramp_ff <= 8'h0;
    end
    else if (ss_cnt_ff >= SS_STEP - 16'h1)
    begin
      ss_cnt_ff <= 16'h0;
      ramp_ff <= (ramp_ff == 8'hFF) ? ramp_ff : ramp_ff + 8'h1;
    end
    else
      ss_cnt_ff <= ss_cnt_ff + 16'h1;
  end

  // Mode cap on the allowed peak
  wire [7:0] mode_cap = (nxt_freq == FQ_LOW) ? `SMPS_CAP_LOW :
                        (nxt_freq == FQ_PEAK) ? `SMPS_CAP_PEAK : `SMPS_CAP_HIGH;
  wire [7:0] nxt_cap = (ramp_ff < mode_cap) ? ramp_ff : mode_cap;

  // ****************************************
  // Fault qualifiers
  // ****************************************
  logic [3:0] c_clr; // Counter clears
  logic [3:0] c_smp; // Counter sample strobes
  logic [3:0] c_hit; // Counter fault inputs
  logic [3:0] c_trip; // Counter trips
  wire off_or_latch = (st_ff == ST_OFF) || (st_ff == ST_LATCH);
  assign c_clr = {!run || !sense.vcc_ovp, !run, !run, off_or_latch};
  assign c_smp = {per_start, ovp_pt, gate_fall, temp_end};
  assign c_hit = {sense.vcc_ovp, sense.sense_ovp, maxd_end, !sense.protect_detect};

  // One counter per consecutive-cycle fault
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cnt
      smps_consec #(.N(CN[gi])) u_cnt
      (
        .clock(clock),
        .rstn(rstn),
        .clr(c_clr[gi]),
        .sample(c_smp[gi]),
        .hit(c_hit[gi]),
        .trip_ff(c_trip[gi])
      );
    end
  endgenerate

  logic bo_done; // Brownout persisted
  logic opp_done; // Overload persisted

  // Brownout persistence
  smps_timer #(.LIMIT(BO_CYC)) u_bo
  (
    .clock(clock),
    .rstn(rstn),
    .run(run && below_bo_ff),
    .done_ff(bo_done)
  );

  // Overpower persistence
  smps_timer #(.LIMIT(OPP_CYC)) u_opp
  (
    .clock(clock),
    .rstn(rstn),
    .run(run && sense.ctrl_overpower),
    .done_ff(opp_done)
  );

  wire latch_ev = c_trip[0] || c_trip[2] || c_trip[3] || sense.junction_hot;
  wire restart_ev = bo_done || c_trip[1] || opp_done;
  wire [`SMPS_FLT_W-1:0] flt_set = {!sense.vcc_lockout && run, sense.junction_hot, c_trip[3],
                                    c_trip[2], c_trip[0], opp_done, c_trip[1], bo_done};

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_rst_left = rst_left_ff;
    if (latch_ev && st_ff != ST_LATCH)
      nxt_st = ST_LATCH;
    else
    begin
      unique case (st_ff)
        ST_OFF:
          if (sense.vcc_startup)
            nxt_st = ST_WAIT;
        ST_WAIT:
          if (!sense.vcc_lockout)
            nxt_st = ST_OFF;
          else if (brownin_ff && protect_ok_ff && en_ff)
            nxt_st = ST_RUN;
        ST_RUN:
          if (restart_ev)
          begin
            nxt_st = ST_DISCH;
            nxt_rst_left = opp_done ? `SMPS_RST_THRICE : `SMPS_RST_ONCE;
          end
          else if (!sense.vcc_lockout)
            nxt_st = ST_OFF;
        ST_DISCH:
          if (!sense.vcc_lockout)
            nxt_st = ST_CHARGE;
        ST_CHARGE:
          if (sense.vcc_startup)
          begin
            nxt_rst_left = rst_left_ff - 2'h1;
            nxt_st = (rst_left_ff == `SMPS_RST_ONCE) ? ST_WAIT : ST_DISCH;
          end
        ST_LATCH:
          if (!sense.vcc_latch_reset)
            nxt_st = ST_OFF;
        default:
          nxt_st = ST_OFF;
      endcase
    end
  end

  // State and drive registers
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st_ff <= ST_OFF;
      rst_left_ff <= 2'h0;
      drive_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      rst_left_ff <= nxt_rst_left;
      drive_ff.gate <= nxt_gate && nxt_st == ST_RUN;
      drive_ff.mains_phase <= ph_end ? !drive_ff.mains_phase : drive_ff.mains_phase;
      drive_ff.hold_sample <= mains_end;
      drive_ff.sense_sample <= ovp_pt;
      drive_ff.line_comp_en <= run && !sense.ctrl_low_power;
      drive_ff.power_down <= (nxt_st == ST_LATCH) || (nxt_st == ST_CHARGE);
      drive_ff.freq_mode <= nxt_freq;
      drive_ff.peak_cap <= run ? nxt_cap : 8'h0;
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_got_ff; // Write address held
  logic w_got_ff; // Write data held
  logic [31:0] waddr_ff; // Held write address
  logic [31:0] wdata_ff; // Held write data
  logic wstrb0_ff; // Held low byte strobe
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  wire do_wr = aw_got_ff && w_got_ff && !bvalid; // Commit write
  wire ar_hs = arvalid && arready;
  wire wr_ctrl = do_wr && waddr_ff == `SMPS_REG_CTRL && wstrb0_ff;
  wire wr_fault = do_wr && waddr_ff == `SMPS_REG_FAULT && wstrb0_ff;
  wire wr_map = waddr_ff == `SMPS_REG_CTRL || waddr_ff == `SMPS_REG_FAULT;
  wire nxt_aw_got = aw_got_ff ? !do_wr : aw_hs;
  wire nxt_w_got = w_got_ff ? !do_wr : w_hs;
  wire nxt_rvalid = ar_hs || (rvalid && !rready);
  wire [31:0] status_w = {21'h0, rst_left_ff, drive_ff.freq_mode, protect_ok_ff,
                          brownin_ff, drive_ff.mains_phase, drive_ff.gate, st_ff};
  wire rd_ctrl = araddr == `SMPS_REG_CTRL;
  wire rd_stat = araddr == `SMPS_REG_STATUS;
  wire rd_flt = araddr == `SMPS_REG_FAULT;
  wire [31:0] rd_val = rd_ctrl ? {31'h0, en_ff} : rd_stat ? status_w :
                       rd_flt ? {24'h0, fault_ff} : 32'h0;

  // Write path
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= 32'h0;
      wdata_ff <= 32'h0;
      wstrb0_ff <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SMPS_RESP_OKAY;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awready <= !nxt_aw_got;
      wready <= !nxt_w_got;
      if (aw_hs)
        waddr_ff <= awaddr;
      if (w_hs)
      begin
        wdata_ff <= wdata;
        wstrb0_ff <= wstrb[0];
      end
      bvalid <= do_wr || (bvalid && !bready);
      if (do_wr)
        bresp <= wr_map ? `SMPS_RESP_OKAY : `SMPS_RESP_SLVERR;
    end
  end

  // Read path
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `SMPS_RESP_OKAY;
    end
    else
    begin
      arready <= !nxt_rvalid;
      rvalid <= nxt_rvalid;
      if (ar_hs)
      begin
        rdata <= rd_val;
        rresp <= (rd_ctrl || rd_stat || rd_flt) ? `SMPS_RESP_OKAY : `SMPS_RESP_SLVERR;
      end
    end
  end

  // Control and sticky fault registers, set beats clear
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      en_ff <= `SMPS_CTRL_RST;
      fault_ff <= '0;
    end
    else
    begin
      if (wr_ctrl)
        en_ff <= wdata_ff[0];
      fault_ff <= (fault_ff & ~(wr_fault ? wdata_ff[`SMPS_FLT_W-1:0] : '0)) | flt_set;
    end
  end

endmodule

// File: smps_consts.svh
// Timing, register and code constants for the protection sequencer
// Operation
// - Internal clock alternates mains and temperature phases
// - Start switching only after stored brown-in sample
// - Brownout after 32 ms below level, restart
// - Brownout restart cycles supply down-up once
// - Four low temperature samples latch protection
// - Held mains sample reused for compensation
// - On-time capped at 80 percent duty
// - Eight maximum-duty strokes trigger restart
// - Maximum-duty restart cycles supply once
// - Overpower timer runs above 400 mV level
// - Overload beyond 180 ms trips overpower
// - Overpower restart cycles supply three times
// - Blank peak comparator after gate turn-on
// - Sample sense overvoltage 2 us after fall
// - Four sense overvoltage cycles latch protection
// - Four supply overvoltage cycles latch, else clear
// - Peak power raises frequency and peak
// - Low power: 25 percent peak, lower frequency
// - Line compensation off at low power
// - Junction overtemperature latches until supply removed
// - Wait for brown-in and protect level
// - Soft-start ramps peak over 3.5 ms
// - Latched fault: power-down until latch reset
// - Lockout in run: stop, wait for recharge
`ifndef SMPS_CONSTS_SVH
`define SMPS_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define SMPS_CLK_HZ 10000000
`define SMPS_BO_MS 32
`define SMPS_OPP_MS 180
`define SMPS_SS_US 3500
`define SMPS_OVP_DLY_US 2
`define SMPS_SW_HZ 65000
`define SMPS_DUTY_PCT 80
`define SMPS_PEAK_PER_PCT 75
`define SMPS_LOW_PER_MUL 4
`define SMPS_BLANK_CYC 3
`define SMPS_PHASE_CYC 500
`define SMPS_CONSEC_N 4
`define SMPS_MAXD_N 8

// ****************************************
// Peak caps and restart counts
// ****************************************
`define SMPS_CAP_LOW 8'h40
`define SMPS_CAP_HIGH 8'hCC
`define SMPS_CAP_PEAK 8'hFF
`define SMPS_RST_ONCE 2'h1
`define SMPS_RST_THRICE 2'h3

// ****************************************
// Register map
// ****************************************
`define SMPS_REG_CTRL 32'h0000_0000
`define SMPS_REG_STATUS 32'h0000_0004
`define SMPS_REG_FAULT 32'h0000_0008
`define SMPS_CTRL_RST 1'h1
`define SMPS_RESP_OKAY 2'h0
`define SMPS_RESP_SLVERR 2'h2
`define SMPS_FLT_W 8

`endif

// File: smps_pkg.sv
// Types shared by the protection sequencer modules
package smps_pkg;

  // Sequencer states, Gray along start, run, restart
  typedef enum logic [2:0]
  {
    ST_OFF = 3'b000,
    ST_WAIT = 3'b001,
    ST_RUN = 3'b011,
    ST_DISCH = 3'b111,
    ST_CHARGE = 3'b101,
    ST_LATCH = 3'b100
  } smps_state_t;

  // Switching frequency modes
  typedef enum logic [1:0]
  {
    FQ_HIGH = 2'b00,
    FQ_PEAK = 2'b01,
    FQ_LOW = 2'b11
  } smps_freq_t;

  // Comparator decisions from the analogue front end
  typedef struct packed
  {
    logic vcc_startup;
    logic vcc_lockout;
    logic vcc_latch_reset;
    logic vcc_ovp;
    logic mains_brownin;
    logic mains_brownout;
    logic protect_detect;
    logic ctrl_overpower;
    logic ctrl_low_power;
    logic ctrl_peak_power;
    logic peak_trip;
    logic sense_ovp;
    logic junction_hot;
  } smps_sense_t;

  // Controls towards the analogue front end and driver
  typedef struct packed
  {
    logic gate;
    logic mains_phase;
    logic hold_sample;
    logic sense_sample;
    logic line_comp_en;
    logic power_down;
    smps_freq_t freq_mode;
    logic [7:0] peak_cap;
  } smps_drive_t;

endpackage

// File: smps_consec.sv
// Consecutive-sample fault counter
`timescale 1ns/100ps
module smps_consec
  import smps_pkg::*;
#(
  parameter logic [3:0] N = 4'h4
)
(
  input wire logic clock, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic clr, // Clear count
  input wire logic sample, // Sample strobe
  input wire logic hit, // Fault seen at sample
  output logic trip_ff // Count reached N
);

  logic [3:0] cnt_ff; // Consecutive hits
  logic [3:0] nxt_cnt; // Next count

  // ****************************************
  // Count hits, clear on miss
  // ****************************************
  assign nxt_cnt = clr ? 4'h0 :
                   !sample ? cnt_ff :
                   !hit ? 4'h0 :
                   (cnt_ff == N) ? cnt_ff : cnt_ff + 4'h1;

  // Count and trip registers
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      cnt_ff <= 4'h0;
      trip_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      trip_ff <= (nxt_cnt == N);
    end
  end

endmodule

// File: smps_timer.sv
// Persistence timer: done once run has held LIMIT cycles
`timescale 1ns/100ps
module smps_timer
  import smps_pkg::*;
#(
  parameter int unsigned LIMIT = 320000
)
(
  input wire logic clock, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic run, // Condition present
  output logic done_ff // Held long enough
);

  localparam logic [31:0] LIM = 32'(LIMIT);
  logic [31:0] cnt_ff; // Elapsed cycles
  logic [31:0] nxt_cnt; // Next count

  // ****************************************
  // Restart on any interruption
  // ****************************************
  assign nxt_cnt = !run ? 32'h0 : (cnt_ff == LIM) ? cnt_ff : cnt_ff + 32'h1;

  // Counter and done registers
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      cnt_ff <= 32'h0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      done_ff <= (nxt_cnt == LIM);
    end
  end

endmodule

// File: smps_props.sv
// Concurrent checks on the protection sequencer ports
`timescale 1ns/100ps
`include "smps_consts.svh"
module smps_props
  import smps_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rstn, // Reset, active low
  input wire smps_sense_t sense, // Comparator inputs
  input wire smps_drive_t drive_ff, // Drive outputs
  input wire logic arvalid, // Read address valid
  input wire logic arready, // Read address ready
  input wire logic rvalid // Read valid
);
  // Longest legal on-time, low mode
  localparam int MAX_ON = `SMPS_CLK_HZ / `SMPS_SW_HZ * `SMPS_LOW_PER_MUL * `SMPS_DUTY_PCT / 100;
  logic [9:0] on_cnt_ff; // Gate-high run length
  logic [9:0] nxt_on_cnt; // Next run length
  assign nxt_on_cnt = drive_ff.gate ? on_cnt_ff + 10'h001 : 10'h000;
  // Count gate-high cycles
  always_ff @(posedge clock)
  begin
    on_cnt_ff <= rstn ? nxt_on_cnt : 10'h000;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // ****************************************
  // Assertions
  // ****************************************
  AST_PD_GATE: assert property (drive_ff.power_down |-> !drive_ff.gate)
    else $error("gate on in power-down");
  AST_HOT: assert property (sense.junction_hot |-> ##[1:3] (drive_ff.power_down && !drive_ff.gate))
    else $error("junction fault not latched");
  AST_BLANK: assert property ($rose(drive_ff.gate) ##[1:3] $fell(drive_ff.gate) |=> drive_ff.peak_cap == 8'h00)
    else $error("stroke ended in blanking");
  AST_DUTY: assert property (on_cnt_ff <= MAX_ON)
    else $error("on-time too long");
  AST_LOWCAP: assert property (drive_ff.freq_mode == FQ_LOW |-> drive_ff.peak_cap <= `SMPS_CAP_LOW)
    else $error("low mode peak too high");
  AST_LINECOMP: assert property (drive_ff.freq_mode == FQ_LOW |-> !drive_ff.line_comp_en)
    else $error("line compensation on at low power");
  AST_PHASE: assert property ($changed(drive_ff.mains_phase) |=> $stable(drive_ff.mains_phase) [*8])
    else $error("phase too short");
  AST_HOLD: assert property (drive_ff.hold_sample |=> !drive_ff.hold_sample)
    else $error("hold strobe too long");
  AST_SAMPLE: assert property (drive_ff.sense_sample |-> !drive_ff.gate)
    else $error("sense sampled in primary stroke");
  AST_RLAT: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  // Main scenarios reached
  cover property ($rose(drive_ff.power_down));
  cover property (drive_ff.freq_mode == FQ_PEAK);
  cover property (drive_ff.freq_mode == FQ_LOW);
endmodule

// File: smps_afe_model.sv
// Behavioural supply, comparators and power stage
`timescale 1ns/100ps
module smps_afe_model
  import smps_pkg::*;
(
  input wire logic clock, // System clock
  input wire smps_drive_t drive_ff, // Drive from design
  input wire logic supply_on, // Mains present
  input wire logic [8:0] trip_at, // Peak trip after cycles
  input wire smps_sense_t ext, // Other comparator levels
  output smps_sense_t sense // Comparator decisions
);
  int v = 0; // Supply level, 50 startup, 20 lockout, 5 latch reset
  int idle = 0; // Cycles without switching or charging
  int on = 0; // Gate-high cycles
  int div = 0; // Slow discharge divider
  logic hi = 1'b0; // Reached startup since last lockout
  // Supply: charge, aux hold or slow discharge
  always @(posedge clock)
  begin
    idle <= (drive_ff.gate || drive_ff.power_down) ? 0 : idle + 1;
    on <= drive_ff.gate ? on + 1 : 0;
    div <= div + 1;
    if (!supply_on)
      v <= (v > 0) ? v - 1 : 0;
    else if (drive_ff.power_down || !hi)
      v <= (v < 60) ? v + 1 : 60;
    else if (idle > 700 && div % 4 == 0)
      v <= v - 1;
    if (v >= 50)
      hi <= 1'b1;
    else if (v <= 20)
      hi <= 1'b0;
  end
  // Comparator outputs
  always_comb
  begin
    sense = ext;
    sense.vcc_startup = v >= 50;
    sense.vcc_lockout = v > 20;
    sense.vcc_latch_reset = v > 5;
    sense.peak_trip = drive_ff.gate && on >= trip_at;
  end
endmodule

// File: tb_top.sv
// Self-checking bench for the protection sequencer
`timescale 1ns/100ps
`include "smps_consts.svh"
module tb_top
  import smps_pkg::*;
;
  localparam int PER = `SMPS_CLK_HZ / `SMPS_SW_HZ; // High-mode period
  logic clock = 1'b0, rstn = 1'b0, supply_on = 1'b1;
  smps_sense_t ext, sense;
  smps_drive_t drive_ff;
  logic [8:0] trip_at = 9'h03C;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rdv;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, g_q = 1'b0, pd_q = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rs;
  int n_fail = 0, n_compared = 0, last_per = 0, per_cnt = 0, last_on = 0, on_cnt = 0, pd_rises = 0, g_rises = 0;
  int i, k, p0, g0;
  int per[3] = '{PER, PER * `SMPS_PEAK_PER_PCT / 100, PER * `SMPS_LOW_PER_MUL};
  logic [7:0] cap[3] = '{`SMPS_CAP_HIGH, `SMPS_CAP_PEAK, `SMPS_CAP_LOW};
  int idx[7] = '{7, 2, 5, 9, 6, 1, 0}; // Sense bit toggled per fault, except fault 1, which drives trip_at
  int fb[7] = '{0, 1, 2, 5, 3, 4, 6}; // Fault register bit
  int npd[7] = '{1, 1, 3, 1, 1, 1, 1}; // Power-down entries
  smps_seq #(.BO_CYC(200), .OPP_CYC(400), .SS_CYC(2560), .PHASE_CYC(20)) u_dut (.clock, .rstn, .sense, .drive_ff,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  smps_afe_model u_afe (.clock, .drive_ff, .supply_on, .trip_at, .ext, .sense);
  initial forever #50 clock = ~clock;
  // Gate and power-down monitor
  always @(posedge clock)
  begin
    g_q <= drive_ff.gate;
    pd_q <= drive_ff.power_down;
    per_cnt <= (drive_ff.gate && !g_q) ? 1 : per_cnt + 1;
    if (drive_ff.gate && !g_q)
    begin
      last_per <= per_cnt;
      g_rises <= g_rises + 1;
    end
    on_cnt <= drive_ff.gate ? on_cnt + 1 : 0;
    if (!drive_ff.gate && on_cnt != 0)
      last_on <= on_cnt;
    if (drive_ff.power_down && !pd_q)
      pd_rises <= pd_rises + 1;
  end
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // AXI4-Lite write
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      k++;
    end
    while (!bvalid && k < 50);
    rs = bresp;
    bready <= 1'b0;
    if (k >= 50)
      n_fail++;
  endtask
  // AXI4-Lite read
  task rd(input logic [31:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      if (arready)
        arvalid <= 1'b0;
      k++;
    end
    while (!rvalid && k < 50);
    rdv = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (k >= 50)
      n_fail++;
  endtask
  // Bounded wait for gate high
  task wait_gate();
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (!drive_ff.gate && k < 20000);
    if (k >= 20000)
      n_fail++;
  endtask
  // Bounded wait for n gate rises
  task wait_rises(input int n);
    g0 = g_rises;
    for (k = 0; k < 5000 && g_rises < g0 + n; k++)
      @(posedge clock);
  endtask
  // Verdict
  task end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge clock);
    n_fail++;
    end_of_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    ext = smps_sense_t'(13'h00C0);
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rd(`SMPS_REG_CTRL);
    chk(rdv, 32'h1);
    rd(32'h10);
    chk(rdv, 32'h0);
    chk(32'(rs), 32'(`SMPS_RESP_SLVERR));
    wr(32'h10, 32'h0);
    chk(32'(rs), 32'(`SMPS_RESP_SLVERR));
    repeat (400) @(posedge clock);
    chk(32'(g_rises), 32'h0);
    rd(`SMPS_REG_STATUS);
    chk(32'(rdv[2:0]), 32'(ST_WAIT));
    wr(`SMPS_REG_CTRL, 32'h0);
    ext.mains_brownin <= 1'b1;
    repeat (100) @(posedge clock);
    chk(32'(g_rises), 32'h0);
    wr(`SMPS_REG_CTRL, 32'h1);
    wait_gate();
    repeat (2) @(posedge clock);
    chk(32'(drive_ff.peak_cap < `SMPS_CAP_HIGH), 32'h1);
    repeat (2600) @(posedge clock);
    chk(32'(drive_ff.peak_cap), 32'(`SMPS_CAP_HIGH));
    trip_at <= 9'h001;
    wait_rises(2);
    chk(32'(last_on), 32'(`SMPS_BLANK_CYC + 1));
    trip_at <= 9'h03C;
    $display("start test done");
    for (i = 0; i < 3; i++)
    begin
      ext.ctrl_peak_power <= (i == 1);
      ext.ctrl_low_power <= (i == 2);
      wait_rises(3);
      chk(32'(last_per), 32'(per[i]));
      chk(32'(drive_ff.peak_cap), 32'(cap[i]));
    end
    ext.ctrl_low_power <= 1'b0;
    $display("mode test done");
    for (i = 0; i < 4; i++)
    begin
      ext.vcc_ovp <= (i % 2 == 0);
      wait_rises(2);
    end
    rd(`SMPS_REG_FAULT);
    chk(rdv, 32'h0);
    for (i = 0; i < 7; i++)
    begin
      wait_gate();
      repeat (20) @(posedge clock);
      p0 = pd_rises;
      if (i == 1)
        trip_at <= 9'h1F4;
      else
        ext[idx[i]] <= ~ext[idx[i]];
      for (k = 0; k < 5000 && pd_rises == p0; k++)
        @(posedge clock);
      if (i == 1)
        trip_at <= 9'h03C;
      else
        ext[idx[i]] <= ~ext[idx[i]];
      if (i == 1)
        chk(32'(last_on), 32'(PER * `SMPS_DUTY_PCT / 100));
      rd(`SMPS_REG_FAULT);
      chk(32'(rdv[fb[i]]), 32'h1);
      wr(`SMPS_REG_FAULT, 32'hFF);
      if (i > 2)
      begin
        g0 = g_rises;
        repeat (300) @(posedge clock);
        chk(32'(g_rises - g0), 32'h0);
        supply_on <= 1'b0;
        repeat (150) @(posedge clock);
        supply_on <= 1'b1;
      end
      wait_gate();
      chk(32'(pd_rises - p0), 32'(npd[i]));
      $display("fault test %0d done", i);
    end
    end_of_test();
  end
endmodule
bind smps_seq smps_props u_props (.clock, .rstn, .sense, .drive_ff, .arvalid, .arready, .rvalid);
